// ---- mbb_slave_end.sv ----
`timescale 1ns/1ps
module mbb_slave_end
  import mbb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  mbb_link_if.slave lnk,
  input wire logic [7:0] my_addr,
  input wire logic [15:0] max_points,
  input wire logic scan_end,
  output logic [15:0] pt_addr,
  output logic pt_kind,
  input wire logic pt_bit,
  output logic other_req,
  output logic [7:0] other_fc,
  output logic busy
);
  mbb_sl_state_t st_r, st_nxt;
  logic [7:0] buf_r [0:5];
  logic [7:0] buf_nxt [0:5];
  logic [3:0] rx_cnt_r, rx_cnt_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic [15:0] idx_r, idx_nxt;
  logic [2:0] bit_r, bit_nxt;
  logic [7:0] byte_r, byte_nxt;
  logic [8:0] left_r, left_nxt;
  logic exc_r, exc_nxt;
  logic [7:0] exc_code_r, exc_code_nxt;
  logic r_valid_r, r_valid_nxt;
  logic [7:0] r_data_r, r_data_nxt;
  logic r_last_r, r_last_nxt;
  logic other_req_r, other_req_nxt;
  logic [7:0] other_fc_r, other_fc_nxt;
  logic crc_clr, crc_en;
  logic [7:0] crc_data;
  logic [15:0] crc_nxt, crc_r;
  logic [15:0] start, qty;
  logic [8:0] byte_cnt;
  logic [7:0] fc;
  logic bit_fc, slave_fc, bcast_fc, qty_bad, rx_take;

  mbb_crc16 u_crc (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .clr(crc_clr),
    .en(crc_en),
    .data(crc_data),
    .crc_nxt(crc_nxt),
    .crc_r(crc_r)
  );

  // decoded query fields
  assign fc = buf_r[1];
  assign start = {buf_r[2], buf_r[3]};
  assign qty = {buf_r[4], buf_r[5]};
  assign byte_cnt = 9'((qty + 16'h0007) >> 3);
  assign bit_fc = (fc == FC_RD_COILS) || (fc == FC_RD_INPUTS);
  assign slave_fc = bit_fc || (fc == FC_RD_HOLD) || (fc == FC_RD_INREG) || (fc == FC_WR_COIL) ||
                    (fc == FC_WR_REG) || (fc == FC_DIAG) || (fc == FC_WR_COILS) || (fc == FC_WR_REGS) ||
                    (fc == FC_REPORT_ID) || (fc == FC_MASK_WR) || (fc == FC_RD_WR);
  assign bcast_fc = (fc == FC_WR_COIL) || (fc == FC_WR_REG) || (fc == FC_WR_COILS) || (fc == FC_WR_REGS);
  assign qty_bad = (qty == 16'h0000) || (qty > MAX_POINTS) || (qty > max_points);
  // half duplex: queries arriving while a reply is under way are ignored
  assign rx_take = lnk.q_valid && ((st_r == SL_IDLE) || (st_r == SL_RX));

  // point image lookup; the address goes out unchanged because it is already zero based
  assign pt_addr = start + idx_r;
  assign pt_kind = (fc == FC_RD_INPUTS);
  assign busy = (st_r != SL_IDLE);
  assign lnk.r_valid = r_valid_r;
  assign lnk.r_data = r_data_r;
  assign lnk.r_last = r_last_r;
  assign other_req = other_req_r;
  assign other_fc = other_fc_r;

  // one shared crc: checks the query on the way in, builds the check field on the way out
  always_comb
  begin
    crc_clr = 1'b0;
    crc_en = 1'b0;
    crc_data = lnk.q_data;
    if (rx_take)
    begin
      crc_en = 1'b1;
      crc_clr = (st_r == SL_IDLE);
    end
    else if (r_valid_nxt && (st_r != SL_CRC))
    begin
      crc_en = 1'b1;
      crc_clr = (st_r == SL_HEAD) && (cnt_r == 2'd0);
      crc_data = r_data_nxt;
    end
  end

  // receive, decide, and walk the reply
  always_comb
  begin
    st_nxt = st_r;
    buf_nxt = buf_r;
    rx_cnt_nxt = rx_cnt_r;
    cnt_nxt = cnt_r;
    idx_nxt = idx_r;
    bit_nxt = bit_r;
    byte_nxt = byte_r;
    left_nxt = left_r;
    exc_nxt = exc_r;
    exc_code_nxt = exc_code_r;
    r_valid_nxt = 1'b0;
    r_data_nxt = r_data_r;
    r_last_nxt = 1'b0;
    other_req_nxt = 1'b0;
    other_fc_nxt = other_fc_r;
    case (st_r)
      SL_IDLE, SL_RX:
      begin
        if (rx_take)
        begin
          if (st_r == SL_IDLE)
          begin
            buf_nxt[0] = lnk.q_data;
            rx_cnt_nxt = 4'h1;
            st_nxt = lnk.q_last ? SL_IDLE : SL_RX;
          end
          else
          begin
            if (rx_cnt_r < QUERY_BODY_LEN)
              buf_nxt[rx_cnt_r[2:0]] = lnk.q_data;
            if (rx_cnt_r != 4'hf)
              rx_cnt_nxt = rx_cnt_r + 4'h1;
            if (lnk.q_last)
            begin
              st_nxt = SL_IDLE;
              if (crc_nxt != 16'h0000)
                st_nxt = SL_IDLE;
              else if (buf_r[0] == BCAST_ADDR)
              begin
                // only writes act on broadcast; reads stay silent
                other_req_nxt = bcast_fc;
                other_fc_nxt = fc;
              end
              else if ((buf_r[0] != my_addr) || (my_addr == BCAST_ADDR))
                st_nxt = SL_IDLE;
              else if (bit_fc)
              begin
                if (rx_cnt_r == QUERY_LAST_IDX)
                begin
                  exc_nxt = qty_bad;
                  exc_code_nxt = EXC_ILL_VALUE;
                  left_nxt = byte_cnt;
                  st_nxt = qty_bad ? SL_HEAD : SL_SCAN;
                  cnt_nxt = 2'd0;
                end
              end
              else if (slave_fc)
              begin
                other_req_nxt = 1'b1;
                other_fc_nxt = fc;
              end
              else
              begin
                exc_nxt = 1'b1;
                exc_code_nxt = EXC_ILL_FUNC;
                cnt_nxt = 2'd0;
                st_nxt = SL_HEAD;
              end
            end
          end
        end
      end
      SL_SCAN:
      begin
        // hold the reply until the point image settles at the end of a scan
        if (scan_end)
        begin
          st_nxt = SL_HEAD;
          cnt_nxt = 2'd0;
          idx_nxt = 16'h0000;
        end
      end
      SL_HEAD:
      begin
        r_valid_nxt = 1'b1;
        case (cnt_r)
          2'd0: r_data_nxt = my_addr;
          2'd1: r_data_nxt = exc_r ? (fc | EXC_FLAG) : fc;
          default: r_data_nxt = exc_r ? exc_code_r : byte_cnt[7:0];
        endcase
        cnt_nxt = cnt_r + 2'd1;
        if (cnt_r == 2'd2)
        begin
          cnt_nxt = 2'd0;
          bit_nxt = 3'd0;
          byte_nxt = 8'h00;
          st_nxt = exc_r ? SL_CRC : SL_FILL;
        end
      end
      SL_FILL:
      begin
        // one point per cycle, lowest bit first; points past the count pad with zero
        byte_nxt[bit_r] = (idx_r < qty) && pt_bit;
        idx_nxt = idx_r + 16'h0001;
        bit_nxt = bit_r + 3'd1;
        if (bit_r == 3'd7)
          st_nxt = SL_DATA;
      end
      SL_DATA:
      begin
        r_valid_nxt = 1'b1;
        r_data_nxt = byte_r;
        left_nxt = left_r - 9'h001;
        bit_nxt = 3'd0;
        byte_nxt = 8'h00;
        st_nxt = (left_r == 9'h001) ? SL_CRC : SL_FILL;
      end
      SL_CRC:
      begin
        r_valid_nxt = 1'b1;
        r_data_nxt = (cnt_r == 2'd0) ? crc_r[7:0] : crc_r[15:8];
        cnt_nxt = cnt_r + 2'd1;
        if (cnt_r == 2'd1)
        begin
          r_last_nxt = 1'b1;
          st_nxt = SL_IDLE;
        end
      end
      default:
        st_nxt = SL_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_r <= SL_IDLE;
      for (int i = 0; i < 6; i++)
        buf_r[i] <= 8'h00;
      rx_cnt_r <= 4'h0;
      cnt_r <= 2'd0;
      idx_r <= 16'h0000;
      bit_r <= 3'd0;
      byte_r <= 8'h00;
      left_r <= 9'h000;
      exc_r <= 1'b0;
      exc_code_r <= 8'h00;
      r_valid_r <= 1'b0;
      r_data_r <= 8'h00;
      r_last_r <= 1'b0;
      other_req_r <= 1'b0;
      other_fc_r <= 8'h00;
    end
    else
    begin
      st_r <= st_nxt;
      buf_r <= buf_nxt;
      rx_cnt_r <= rx_cnt_nxt;
      cnt_r <= cnt_nxt;
      idx_r <= idx_nxt;
      bit_r <= bit_nxt;
      byte_r <= byte_nxt;
      left_r <= left_nxt;
      exc_r <= exc_nxt;
      exc_code_r <= exc_code_nxt;
      r_valid_r <= r_valid_nxt;
      r_data_r <= r_data_nxt;
      r_last_r <= r_last_nxt;
      other_req_r <= other_req_nxt;
      other_fc_r <= other_fc_nxt;
    end
  end
endmodule

// ---- mbb_pkg.sv ----
package mbb_pkg;
  // function codes
  localparam logic [7:0] FC_RD_COILS = 8'h01;
  localparam logic [7:0] FC_RD_INPUTS = 8'h02;
  localparam logic [7:0] FC_RD_HOLD = 8'h03;
  localparam logic [7:0] FC_RD_INREG = 8'h04;
  localparam logic [7:0] FC_WR_COIL = 8'h05;
  localparam logic [7:0] FC_WR_REG = 8'h06;
  localparam logic [7:0] FC_DIAG = 8'h08;
  localparam logic [7:0] FC_WR_COILS = 8'h0f;
  localparam logic [7:0] FC_WR_REGS = 8'h10;
  localparam logic [7:0] FC_REPORT_ID = 8'h11;
  localparam logic [7:0] FC_MASK_WR = 8'h16;
  localparam logic [7:0] FC_RD_WR = 8'h17;
  // addressing, limits and exception answers
  localparam logic [7:0] BCAST_ADDR = 8'h00;
  localparam logic [15:0] MAX_POINTS = 16'h07d0;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_ILL_FUNC = 8'h01;
  localparam logic [7:0] EXC_ILL_VALUE = 8'h03;
  // frame layout: addr, fc, start hi/lo, qty hi/lo, crc lo/hi
  localparam logic [3:0] QUERY_BODY_LEN = 4'h6;
  localparam logic [3:0] QUERY_LAST_IDX = 4'h7;
  localparam logic [8:0] RSP_OVERHEAD = 9'h005;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  // reply timeout on the master end
  localparam int CLK_MHZ = 40;
  localparam int RESP_TIMEOUT_US = 1000;
  localparam int RESP_TIMEOUT_CYC = RESP_TIMEOUT_US * CLK_MHZ;

  typedef enum logic [2:0] {SL_IDLE, SL_RX, SL_SCAN, SL_HEAD, SL_FILL, SL_DATA, SL_CRC} mbb_sl_state_t;
  typedef enum logic [1:0] {MS_IDLE, MS_SEND, MS_WAIT} mbb_ms_state_t;
endpackage

// ---- mbb_link_if.sv ----
`timescale 1ns/1ps
interface mbb_link_if (input wire logic sys_clk);
  // query stream, master to slave
  logic q_valid;
  logic [7:0] q_data;
  logic q_last;
  // answer stream, slave to master
  logic r_valid;
  logic [7:0] r_data;
  logic r_last;
  modport master (output q_valid, output q_data, output q_last, input r_valid, input r_data, input r_last);
  modport slave (input q_valid, input q_data, input q_last, output r_valid, output r_data, output r_last);
endinterface

// ---- mbb_crc16.sv ----
`timescale 1ns/1ps
module mbb_crc16
  import mbb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clr,
  input wire logic en,
  input wire logic [7:0] data,
  output logic [15:0] crc_nxt,
  output logic [15:0] crc_r
);
  // byte-wide reflected crc; clr restarts from the seed in the same cycle
  always_comb
  begin
    logic [15:0] c;
    c = clr ? CRC_INIT : crc_r;
    c = c ^ {8'h00, data};
    for (int i = 0; i < 8; i++)
    begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    crc_nxt = c;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      crc_r <= CRC_INIT;
    else if (en)
      crc_r <= crc_nxt;
  end
endmodule

// ---- mbb_master_end.sv ----
`timescale 1ns/1ps
module mbb_master_end
  import mbb_pkg::*;
#(
  parameter int TIMEOUT_CYC = RESP_TIMEOUT_CYC
)
(
  input wire logic sys_clk,
  input wire logic rstn,
  mbb_link_if.master lnk,
  input wire logic cmd_valid,
  input wire logic [15:0] cmd_local,
  input wire logic [7:0] cmd_slave,
  input wire logic [7:0] cmd_fc,
  input wire logic [15:0] cmd_start,
  input wire logic [15:0] cmd_qty,
  output logic cmd_ready,
  output logic cmd_err,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic [15:0] rsp_local,
  output logic done,
  output logic done_ok
);
  mbb_ms_state_t st_r, st_nxt;
  logic [7:0] frm_r [0:5];
  logic [7:0] frm_nxt [0:5];
  logic [15:0] local_r, local_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [8:0] rx_cnt_r, rx_cnt_nxt;
  logic [8:0] bc_r, bc_nxt;
  logic hdr_ok_r, hdr_ok_nxt;
  logic [31:0] tmo_r, tmo_nxt;
  logic q_valid_r, q_valid_nxt, q_last_r, q_last_nxt;
  logic [7:0] q_data_r, q_data_nxt;
  logic cmd_err_r, cmd_err_nxt, rsp_valid_r, rsp_valid_nxt, done_r, done_nxt, ok_r, ok_nxt;
  logic [7:0] rsp_data_r, rsp_data_nxt;
  logic [15:0] rsp_local_r, rsp_local_nxt;
  logic crc_clr, crc_en;
  logic [7:0] crc_data;
  logic [15:0] crc_nxt, crc_r;
  logic issue_fc, bit_fc, read_fc, refuse;

  mbb_crc16 u_crc (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .clr(crc_clr),
    .en(crc_en),
    .data(crc_data),
    .crc_nxt(crc_nxt),
    .crc_r(crc_r)
  );

  // only two-word queries are framed here, so 15 and 16 are refused as well
  assign issue_fc = (cmd_fc >= FC_RD_COILS) && (cmd_fc <= FC_WR_REG);
  assign bit_fc = (cmd_fc == FC_RD_COILS) || (cmd_fc == FC_RD_INPUTS);
  assign read_fc = bit_fc || (cmd_fc == FC_RD_HOLD) || (cmd_fc == FC_RD_INREG);
  assign refuse = !issue_fc || (read_fc && (cmd_slave == BCAST_ADDR)) ||
                  (bit_fc && ((cmd_qty == 16'h0000) || (cmd_qty > MAX_POINTS)));
  assign cmd_ready = (st_r == MS_IDLE);
  assign lnk.q_valid = q_valid_r;
  assign lnk.q_data = q_data_r;
  assign lnk.q_last = q_last_r;
  assign cmd_err = cmd_err_r;
  assign rsp_valid = rsp_valid_r;
  assign rsp_data = rsp_data_r;
  assign rsp_local = rsp_local_r;
  assign done = done_r;
  assign done_ok = ok_r;

  // crc shared between the outgoing query and the incoming reply
  always_comb
  begin
    crc_clr = 1'b0;
    crc_en = 1'b0;
    crc_data = q_data_nxt;
    if ((st_r == MS_SEND) && (cnt_r < QUERY_BODY_LEN))
    begin
      crc_en = 1'b1;
      crc_clr = (cnt_r == 4'h0);
    end
    else if ((st_r == MS_WAIT) && lnk.r_valid)
    begin
      crc_en = 1'b1;
      crc_clr = (rx_cnt_r == 9'h000);
      crc_data = lnk.r_data;
    end
  end

  always_comb
  begin
    st_nxt = st_r;
    frm_nxt = frm_r;
    local_nxt = local_r;
    cnt_nxt = cnt_r;
    rx_cnt_nxt = rx_cnt_r;
    bc_nxt = bc_r;
    hdr_ok_nxt = hdr_ok_r;
    tmo_nxt = tmo_r;
    q_valid_nxt = 1'b0;
    q_data_nxt = q_data_r;
    q_last_nxt = 1'b0;
    cmd_err_nxt = 1'b0;
    rsp_valid_nxt = 1'b0;
    rsp_data_nxt = rsp_data_r;
    rsp_local_nxt = rsp_local_r;
    done_nxt = 1'b0;
    ok_nxt = ok_r;
    case (st_r)
      MS_IDLE:
      begin
        if (cmd_valid && refuse)
          cmd_err_nxt = 1'b1;
        else if (cmd_valid)
        begin
          // local part kept here, remote part becomes the query
          local_nxt = cmd_local;
          frm_nxt[0] = cmd_slave;
          frm_nxt[1] = cmd_fc;
          frm_nxt[2] = cmd_start[15:8];
          frm_nxt[3] = cmd_start[7:0];
          frm_nxt[4] = cmd_qty[15:8];
          frm_nxt[5] = cmd_qty[7:0];
          cnt_nxt = 4'h0;
          st_nxt = MS_SEND;
        end
      end
      MS_SEND:
      begin
        q_valid_nxt = 1'b1;
        if (cnt_r < QUERY_BODY_LEN)
          q_data_nxt = frm_r[cnt_r[2:0]];
        else
          q_data_nxt = (cnt_r == QUERY_LAST_IDX) ? crc_r[15:8] : crc_r[7:0];
        cnt_nxt = cnt_r + 4'h1;
        if (cnt_r == QUERY_LAST_IDX)
        begin
          q_last_nxt = 1'b1;
          rx_cnt_nxt = 9'h000;
          tmo_nxt = 32'h0000_0000;
          hdr_ok_nxt = 1'b1;
          st_nxt = (frm_r[0] == BCAST_ADDR) ? MS_IDLE : MS_WAIT;
        end
      end
      MS_WAIT:
      begin
        tmo_nxt = tmo_r + 32'h0000_0001;
        if (lnk.r_valid)
        begin
          if (rx_cnt_r != 9'h1ff)
            rx_cnt_nxt = rx_cnt_r + 9'h001;
          if (rx_cnt_r == 9'h000)
            hdr_ok_nxt = (lnk.r_data == frm_r[0]);
          else if (rx_cnt_r == 9'h001)
            hdr_ok_nxt = hdr_ok_r && (lnk.r_data == frm_r[1]);
          else if (rx_cnt_r == 9'h002)
            bc_nxt = {1'b0, lnk.r_data};
          else if (hdr_ok_r && (frm_r[1] <= FC_RD_INREG) && (rx_cnt_r < bc_r + 9'h003))
          begin
            // data bytes go out as they come; done_ok tells whether to keep them
            rsp_valid_nxt = 1'b1;
            rsp_data_nxt = lnk.r_data;
            rsp_local_nxt = local_r + 16'(rx_cnt_r - 9'h003);
          end
          if (lnk.r_last)
          begin
            done_nxt = 1'b1;
            ok_nxt = (crc_nxt == 16'h0000) && hdr_ok_r &&
                     ((frm_r[1] > FC_RD_INREG) || (rx_cnt_r == bc_r + RSP_OVERHEAD - 9'h001));
            st_nxt = MS_IDLE;
          end
        end
        else if (tmo_r >= 32'(TIMEOUT_CYC - 1))
        begin
          done_nxt = 1'b1;
          ok_nxt = 1'b0;
          st_nxt = MS_IDLE;
        end
      end
      default:
        st_nxt = MS_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_r <= MS_IDLE;
      for (int i = 0; i < 6; i++)
        frm_r[i] <= 8'h00;
      local_r <= 16'h0000;
      cnt_r <= 4'h0;
      rx_cnt_r <= 9'h000;
      bc_r <= 9'h000;
      hdr_ok_r <= 1'b0;
      tmo_r <= 32'h0000_0000;
      q_valid_r <= 1'b0;
      q_data_r <= 8'h00;
      q_last_r <= 1'b0;
      cmd_err_r <= 1'b0;
      rsp_valid_r <= 1'b0;
      rsp_data_r <= 8'h00;
      rsp_local_r <= 16'h0000;
      done_r <= 1'b0;
      ok_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      frm_r <= frm_nxt;
      local_r <= local_nxt;
      cnt_r <= cnt_nxt;
      rx_cnt_r <= rx_cnt_nxt;
      bc_r <= bc_nxt;
      hdr_ok_r <= hdr_ok_nxt;
      tmo_r <= tmo_nxt;
      q_valid_r <= q_valid_nxt;
      q_data_r <= q_data_nxt;
      q_last_r <= q_last_nxt;
      cmd_err_r <= cmd_err_nxt;
      rsp_valid_r <= rsp_valid_nxt;
      rsp_data_r <= rsp_data_nxt;
      rsp_local_r <= rsp_local_nxt;
      done_r <= done_nxt;
      ok_r <= ok_nxt;
    end
  end
endmodule

// ---- mbb_properties.sv ----
`timescale 1ns/1ps
module mbb_properties
  import mbb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic q_valid,
  input wire logic [7:0] q_data,
  input wire logic q_last,
  input wire logic r_valid,
  input wire logic [7:0] r_data,
  input wire logic r_last
);
  logic [3:0] qn_r;
  logic [8:0] rn_r;
  logic [7:0] qa_r, qf_r, qh_r, rf_r;
  logic [15:0] qq_r;
  logic bp_r;
  logic [15:0] bcw;
  logic [7:0] pad;
  logic qrd, rd;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);
  // byte positions in the running query and reply, and the query fields a reply depends on
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      qn_r <= 4'h0;
      rn_r <= 9'h000;
      qa_r <= 8'h00;
      qf_r <= 8'h00;
      qh_r <= 8'h00;
      rf_r <= 8'h00;
      qq_r <= 16'h0000;
      bp_r <= 1'b0;
    end
    else
    begin
      if (q_valid)
        qn_r <= q_last ? 4'h0 : qn_r + 4'h1;
      if (q_valid && qn_r == 4'h0)
        qa_r <= q_data;
      if (q_valid && qn_r == 4'h1)
        qf_r <= q_data;
      if (q_valid && qn_r == 4'h4)
        qh_r <= q_data;
      if (q_valid && qn_r == 4'h5)
        qq_r <= {qh_r, q_data};
      if (r_valid)
        rn_r <= r_last ? 9'h000 : rn_r + 9'h001;
      if (r_valid && rn_r == 9'h001)
        rf_r <= r_data;
      // a broadcast stays pending until the next query opens; nobody may answer it meanwhile
      if (q_valid)
        bp_r <= q_last && qa_r == BCAST_ADDR;
    end
  end
  // expected byte count and the padding mask of the last data byte
  assign bcw = (qq_r + 16'h0007) >> 3;
  assign pad = (qq_r[2:0] == 3'h0) ? 8'h00 : 8'hff << qq_r[2:0];
  assign qrd = qf_r == FC_RD_COILS || qf_r == FC_RD_INPUTS;
  assign rd = qrd && rf_r == qf_r;
  chk_query_len: assert property (q_last |-> q_valid && qn_r == 4'h7)
    else $error("query frame length wrong");
  chk_query_burst: assert property (q_valid && !q_last |=> q_valid)
    else $error("query bytes not back to back");
  chk_master_codes: assert property (q_valid && qn_r == 4'h1 |-> q_data inside {[FC_RD_COILS:FC_WR_REG]})
    else $error("master sent an unsupported code");
  chk_no_bcast_read: assert property (q_valid && qn_r == 4'h1 && qa_r == BCAST_ADDR |-> q_data > FC_RD_INREG)
    else $error("read sent to broadcast address");
  chk_qty_range: assert property (q_valid && qn_r == 4'h5 && qrd |-> {qh_r, q_data} inside {[16'h0001:MAX_POINTS]})
    else $error("read quantity out of range");
  chk_bcast_silent: assert property (bp_r |-> !r_valid)
    else $error("reply to a broadcast");
  chk_reply_addr: assert property (r_valid && rn_r == 9'h000 |-> r_data == qa_r)
    else $error("reply address differs");
  chk_reply_code: assert property (r_valid && rn_r == 9'h001 |-> r_data == qf_r || r_data == (qf_r | EXC_FLAG))
    else $error("reply code differs");
  chk_byte_count: assert property (r_valid && rn_r == 9'h002 && rd |-> r_data == bcw[7:0])
    else $error("byte count wrong");
  chk_reply_len: assert property (r_valid && r_last && rd |-> rn_r == bcw[8:0] + 9'h004)
    else $error("reply length wrong");
  chk_pad_zero: assert property (r_valid && rd && rn_r == bcw[8:0] + 9'h002 |-> (r_data & pad) == 8'h00)
    else $error("padding bits not zero");
endmodule

// ---- modbus_bit_read_handler_bench.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin num_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module modbus_bit_read_handler_bench
  import mbb_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic cmd_valid = 1'b0;
  logic [7:0] cmd_slave = 8'h00;
  logic [7:0] cmd_fc = 8'h00;
  logic [15:0] cmd_start = 16'h0000;
  logic [15:0] cmd_qty = 16'h0000;
  logic [15:0] max_pts = MAX_POINTS;
  logic scan_end = 1'b0;
  logic [5:0] scn = 6'h00;
  logic cmd_ready, cmd_err, rsp_valid, done, done_ok, busy, busy2, other_req, other_req2, pt_kind, pt_kind2;
  logic [7:0] rsp_data, other_fc, other_fc2;
  logic [15:0] rsp_local, pt_addr, pt_addr2;
  logic [7:0] qb[$], rb[$], r2b[$], db[$];
  logic [15:0] lb[$];
  logic [31:0] bad[5] = '{32'h0b07_0001, 32'h0b08_0001, 32'h0001_0001, 32'h0b02_0000, 32'h0b01_07d1};
  int num_errors = 0;
  int num_checks = 0;
  int n_done, n_err, n_oth, n_oth2;
  // point image seen by both slaves; a fixed function so expectations need no design output
  function automatic logic img(input logic [15:0] a, input logic k);
    return k ? a[0] ^ a[3] ^ a[4] : a[1] ^ a[2] ^ a[5];
  endfunction
  function automatic logic [15:0] crc(input logic [7:0] b[$], input int n);
    logic [15:0] c;
    c = CRC_INIT;
    for (int i = 0; i < n; i++)
    begin
      c = c ^ {8'h00, b[i]};
      for (int j = 0; j < 8; j++)
        c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
    end
    return c;
  endfunction
  always #12.5 sys_clk = ~sys_clk;
  mbb_link_if mbb_link_if_i (.sys_clk(sys_clk));
  mbb_link_if link2 (.sys_clk(sys_clk));
  mbb_master_end #(.TIMEOUT_CYC(3000)) mbb_master_end_i (.sys_clk(sys_clk), .rstn(rstn), .lnk(mbb_link_if_i),
    .cmd_valid(cmd_valid), .cmd_local(16'h0100), .cmd_slave(cmd_slave), .cmd_fc(cmd_fc), .cmd_start(cmd_start),
    .cmd_qty(cmd_qty), .cmd_ready(cmd_ready), .cmd_err(cmd_err), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_local(rsp_local), .done(done), .done_ok(done_ok));
  mbb_slave_end mbb_slave_end_i (.sys_clk(sys_clk), .rstn(rstn), .lnk(mbb_link_if_i), .my_addr(8'h0b),
    .max_points(max_pts), .scan_end(scan_end), .pt_addr(pt_addr), .pt_kind(pt_kind),
    .pt_bit(img(pt_addr, pt_kind)), .other_req(other_req), .other_fc(other_fc), .busy(busy));
  // second slave, fed by the bench so that broken frames can be sent
  mbb_slave_end mbb_slave_end_i2 (.sys_clk(sys_clk), .rstn(rstn), .lnk(link2), .my_addr(8'h0b),
    .max_points(max_pts), .scan_end(scan_end), .pt_addr(pt_addr2), .pt_kind(pt_kind2),
    .pt_bit(img(pt_addr2, pt_kind2)), .other_req(other_req2), .other_fc(other_fc2), .busy(busy2));
  mbb_properties mbb_properties_i (.sys_clk(sys_clk), .rstn(rstn), .q_valid(mbb_link_if_i.q_valid),
    .q_data(mbb_link_if_i.q_data), .q_last(mbb_link_if_i.q_last), .r_valid(mbb_link_if_i.r_valid),
    .r_data(mbb_link_if_i.r_data), .r_last(mbb_link_if_i.r_last));
  // scans end every 64 cycles, so a reply waits for the next boundary
  always @(posedge sys_clk)
  begin
    #1;
    scn = scn + 6'h01;
    scan_end = (scn == 6'h00);
  end
  // record wire bytes and one-cycle pulses
  always @(posedge sys_clk)
  begin
    if (mbb_link_if_i.q_valid === 1'b1) qb.push_back(mbb_link_if_i.q_data);
    if (mbb_link_if_i.r_valid === 1'b1) rb.push_back(mbb_link_if_i.r_data);
    if (link2.r_valid === 1'b1) r2b.push_back(link2.r_data);
    if (rsp_valid === 1'b1) db.push_back(rsp_data);
    if (rsp_valid === 1'b1) lb.push_back(rsp_local);
    if (done === 1'b1) n_done++;
    if (cmd_err === 1'b1) n_err++;
    if (other_req === 1'b1) n_oth++;
    if (other_req2 === 1'b1) n_oth2++;
  end
  task automatic conclude();
    $display("errors=%0d checks=%0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // one master command; a result that never comes is a hang only where one is due
  task automatic cmd(input logic [7:0] sl, input logic [7:0] fc, input logic [15:0] st, input logic [15:0] qt,
    input bit need);
    int i;
    qb.delete();
    rb.delete();
    db.delete();
    lb.delete();
    {n_done, n_err, n_oth} = '0;
    `CHK(cmd_ready, 1'b1)
    {cmd_slave, cmd_fc, cmd_start, cmd_qty} = {sl, fc, st, qt};
    cmd_valid = 1'b1;
    @(posedge sys_clk);
    #1;
    cmd_valid = 1'b0;
    for (i = 0; i < 4000 && n_done == 0 && n_err == 0; i++)
      @(posedge sys_clk);
    if (need && i == 4000)
    begin
      num_errors++;
      conclude();
    end
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  // bit read to slave 11, checked on the wire and at the master's user side
  task automatic rd(input logic [7:0] fc, input logic [15:0] st, input logic [15:0] qt);
    logic [7:0] e;
    int nb;
    nb = (int'(qt) + 7) / 8;
    cmd(8'h0b, fc, st, qt, 1);
    `CHK(done_ok, 1'b1)
    `CHK({qb[2], qb[3]}, st)
    `CHK({qb[4], qb[5]}, qt)
    `CHK({qb[7], qb[6]}, crc(qb, 6))
    `CHK(rb[1], fc)
    `CHK(rb[2], 8'(nb))
    `CHK(rb.size(), nb + 5)
    `CHK({rb[nb+4], rb[nb+3]}, crc(rb, nb + 3))
    `CHK(db.size(), nb)
    for (int j = 0; j < nb; j++)
    begin
      e = 8'h00;
      for (int b = 0; b < 8; b++)
        if (j * 8 + b < qt) e[b] = img(st + 16'(j * 8 + b), fc == FC_RD_INPUTS);
      `CHK(rb[j+3], e)
      `CHK(db[j], e)
      `CHK(lb[j], 16'h0100 + 16'(j))
    end
  endtask
  // eight-byte query straight onto the second link, check field optionally corrupted
  task automatic send2(input logic [7:0] a, input logic [7:0] f, input logic brk);
    logic [7:0] fr[$];
    logic [15:0] c;
    fr = '{a, f, 8'h00, 8'h00, 8'h00, 8'h01};
    c = crc(fr, 6) ^ {15'h0000, brk};
    fr.push_back(c[7:0]);
    fr.push_back(c[15:8]);
    r2b.delete();
    n_oth2 = 0;
    foreach (fr[i])
    begin
      {link2.q_valid, link2.q_data, link2.q_last} = {1'b1, fr[i], i == 7};
      @(posedge sys_clk);
      #1;
    end
    {link2.q_valid, link2.q_data, link2.q_last} = {1'b0, ~link2.q_data, 1'b0};
    repeat (150) @(posedge sys_clk);
    #1;
  endtask
  initial
  begin
    {link2.q_valid, link2.q_data, link2.q_last} = 10'h000;
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK(busy, 1'b0)
    rstn = 1'b1;
    rd(FC_RD_COILS, 16'h0013, 16'h0025);
    rd(FC_RD_INPUTS, 16'h00c4, 16'h0016);
    rd(FC_RD_COILS, 16'hfff8, 16'h0008);
    rd(FC_RD_INPUTS, 16'h0100, MAX_POINTS);
    max_pts = 16'h0010;
    rd(FC_RD_COILS, 16'h0000, 16'h0010);
    rd(FC_RD_COILS, 16'h0010, 16'h0010);
    cmd(8'h0b, FC_RD_COILS, 16'h0000, 16'h0011, 1);
    `CHK({rb[1], rb[2], done_ok}, {FC_RD_COILS | EXC_FLAG, EXC_ILL_VALUE, 1'b0})
    foreach (bad[k])
    begin
      cmd(bad[k][31:24], bad[k][23:16], 16'h0000, bad[k][15:0], 1);
      `CHK({n_err, qb.size()}, {32'sd1, 32'sd0})
    end
    for (int f = 3; f <= 6; f++)
    begin
      cmd(8'h0b, 8'(f), 16'h0000, (f == 5) ? 16'h0000 : 16'h0001, 1);
      `CHK({n_oth, other_fc, done_ok}, {32'sd1, 8'(f), 1'b0})
    end
    cmd(BCAST_ADDR, FC_WR_COIL, 16'h0000, 16'h0000, 0);
    `CHK({n_oth, n_done, rb.size()}, {32'sd1, 32'sd0, 32'sd0})
    send2(8'h0b, FC_RD_COILS, 1'b1);
    `CHK(r2b.size(), 0)
    send2(8'h0b, FC_RD_COILS, 1'b0);
    `CHK({r2b.size(), r2b[3]}, {32'sd6, 7'h00, img(16'h0000, 1'b0)})
    send2(BCAST_ADDR, FC_RD_INPUTS, 1'b0);
    `CHK({r2b.size(), n_oth2}, {32'sd0, 32'sd0})
    send2(8'h0b, FC_WR_COILS, 1'b0);
    `CHK({n_oth2, other_fc2}, {32'sd1, FC_WR_COILS})
    send2(8'h0b, FC_WR_REGS, 1'b0);
    `CHK({n_oth2, other_fc2}, {32'sd1, FC_WR_REGS})
    send2(8'h0b, FC_DIAG, 1'b0);
    `CHK({n_oth2, other_fc2}, {32'sd1, FC_DIAG})
    send2(8'h0b, FC_REPORT_ID, 1'b0);
    `CHK({n_oth2, other_fc2}, {32'sd1, FC_REPORT_ID})
    send2(8'h0b, FC_MASK_WR, 1'b0);
    `CHK({n_oth2, other_fc2}, {32'sd1, FC_MASK_WR})
    send2(8'h0b, FC_RD_WR, 1'b0);
    `CHK({n_oth2, other_fc2}, {32'sd1, FC_RD_WR})
    send2(8'h0b, 8'h07, 1'b0);
    `CHK({r2b[1], r2b[2]}, {8'h87, EXC_ILL_FUNC})
    conclude();
  end
endmodule
